// [src/mvd_pkg.sv]
// Constants shared by the memory-mapped paravirtual device transport.
package mvd_pkg;

    localparam int unsigned ADDR_W = 12;

    localparam logic [11:0] OFF_IDENT       = 12'h000;
    localparam logic [11:0] OFF_VERSION     = 12'h004;
    localparam logic [11:0] OFF_DEV_TYPE    = 12'h008;
    localparam logic [11:0] OFF_MAKER       = 12'h00c;
    localparam logic [11:0] OFF_OFFER_FEAT  = 12'h010;
    localparam logic [11:0] OFF_OFFER_SEL   = 12'h014;
    localparam logic [11:0] OFF_ACCEPT_FEAT = 12'h020;
    localparam logic [11:0] OFF_ACCEPT_SEL  = 12'h024;
    localparam logic [11:0] OFF_PAGE_BYTES  = 12'h028;
    localparam logic [11:0] OFF_VQ_SEL      = 12'h030;
    localparam logic [11:0] OFF_VQ_MAX      = 12'h034;
    localparam logic [11:0] OFF_VQ_ELEMS    = 12'h038;
    localparam logic [11:0] OFF_VQ_ALIGN    = 12'h03c;
    localparam logic [11:0] OFF_VQ_READY    = 12'h03c;
    localparam logic [11:0] OFF_VQ_PFN      = 12'h040;
    localparam logic [11:0] OFF_VQ_KICK     = 12'h050;
    localparam logic [11:0] OFF_IRQ_CAUSE   = 12'h060;
    localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h064;
    localparam logic [11:0] OFF_STATUS      = 12'h070;
    localparam logic [11:0] OFF_DESC_LO     = 12'h080;
    localparam logic [11:0] OFF_DESC_HI     = 12'h084;
    localparam logic [11:0] OFF_OFFER_LO    = 12'h090;
    localparam logic [11:0] OFF_OFFER_HI    = 12'h094;
    localparam logic [11:0] OFF_DONE_LO     = 12'h0a0;
    localparam logic [11:0] OFF_DONE_HI     = 12'h0a4;
    localparam logic [11:0] OFF_CFG_GEN     = 12'h0fc;
    localparam logic [11:0] OFF_CFG_SPACE   = 12'h100;

    localparam logic [31:0] IDENT_VALUE     = 32'h7472_6976;
    localparam logic [31:0] VERSION_LEGACY  = 32'h0000_0001;
    localparam logic [31:0] VERSION_CURRENT = 32'h0000_0002;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    localparam int unsigned IRQ_USED_BIT = 0;
    localparam int unsigned IRQ_CFG_BIT  = 1;
    localparam int unsigned IRQ_W        = 2;

    // Field codes that steer a write into one queue's register set.
    localparam logic [3:0] QF_ELEMS   = 4'h0;
    localparam logic [3:0] QF_ALIGN   = 4'h1;
    localparam logic [3:0] QF_PFN     = 4'h2;
    localparam logic [3:0] QF_READY   = 4'h3;
    localparam logic [3:0] QF_DESC_LO = 4'h4;
    localparam logic [3:0] QF_DESC_HI = 4'h5;
    localparam logic [3:0] QF_OFFR_LO = 4'h6;
    localparam logic [3:0] QF_OFFR_HI = 4'h7;
    localparam logic [3:0] QF_DONE_LO = 4'h8;
    localparam logic [3:0] QF_DONE_HI = 4'h9;
    localparam logic [3:0] QF_NONE    = 4'hf;

endpackage : mvd_pkg

// [src/mvd_queue.sv]
// Register set of one virtual queue.
`timescale 1ns/1ps
`default_nettype none
module mvd_queue (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_field,
    input  wire logic [31:0] wr_data,
    input  wire logic        dev_reset,
    output logic             ready_q,
    output logic [31:0]      elems_q,
    output logic [31:0]      align_q,
    output logic [31:0]      pfn_q,
    output logic [63:0]      desc_q,
    output logic [63:0]      offr_q,
    output logic [63:0]      done_q
);
    import mvd_pkg::*;

    wire f_elems = wr_en && (wr_field == QF_ELEMS);
    wire f_align = wr_en && (wr_field == QF_ALIGN);
    wire f_pfn   = wr_en && (wr_field == QF_PFN);
    wire f_ready = wr_en && (wr_field == QF_READY);
    wire f_dlo   = wr_en && (wr_field == QF_DESC_LO);
    wire f_dhi   = wr_en && (wr_field == QF_DESC_HI);
    wire f_olo   = wr_en && (wr_field == QF_OFFR_LO);
    wire f_ohi   = wr_en && (wr_field == QF_OFFR_HI);
    wire f_ulo   = wr_en && (wr_field == QF_DONE_LO);
    wire f_uhi   = wr_en && (wr_field == QF_DONE_HI);

    // A device reset stops the queue in both layouts; addresses are kept.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b0;
            pfn_q   <= ZERO_WORD;
        end else if (dev_reset) begin
            ready_q <= 1'b0;
            pfn_q   <= ZERO_WORD;
        end else begin
            if (f_ready) ready_q <= wr_data[0];
            if (f_pfn) pfn_q <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            elems_q <= ZERO_WORD;
            align_q <= ZERO_WORD;
            desc_q  <= {ZERO_WORD, ZERO_WORD};
            offr_q  <= {ZERO_WORD, ZERO_WORD};
            done_q  <= {ZERO_WORD, ZERO_WORD};
        end else begin
            if (f_elems) elems_q <= wr_data;
            if (f_align) align_q <= wr_data;
            if (f_dlo) desc_q[31:0] <= wr_data;
            if (f_dhi) desc_q[63:32] <= wr_data;
            if (f_olo) offr_q[31:0] <= wr_data;
            if (f_ohi) offr_q[63:32] <= wr_data;
            if (f_ulo) done_q[31:0] <= wr_data;
            if (f_uhi) done_q[63:32] <= wr_data;
        end
    end

    AST_PFN_CLEARED_BY_RESET: assert property (@(posedge mclk) disable iff (!resetn)
        dev_reset |=> (pfn_q == ZERO_WORD) && !ready_q)
        else $error("queue not stopped by device reset");

endmodule : mvd_queue
`default_nettype wire

// [src/mvd_top.sv]
// Register transport of the memory-mapped paravirtual device.
//
// Operation
// - Maximum-size register returns the selected queue's limit, zero if absent.
// - One interrupt output is raised while any cause bit is set.
// - Causes are raised for used buffer updates and configuration changes.
// - Legacy layout version register reads as one.
// - Driver writes page size before queues; device keeps it for addressing.
// - Legacy selection steers maximum, size, alignment and page-number access.
// - Size register takes the selected queue's element count.
// - Alignment register takes the used-ring boundary for the selected queue.
// - Page-number register holds queue start page; nonzero means in use.
// - Status reads flags, nonzero writes set, zero resets and stops queues.
// - Writing a queue index to the kick register signals new buffers.
// - Cause bit 0 flags used ring update, bit 1 configuration change.
// - Each set bit written to the clear register clears that cause.
// - Register values are little-endian.
`timescale 1ns/1ps
`default_nettype none
module mvd_top #(
    parameter int unsigned NUM_QUEUES  = 2,
    parameter int unsigned QUEUE_MAX   = 256,
    parameter int unsigned FEAT_WORDS  = 2,
    parameter int unsigned CFG_WORDS   = 4,
    parameter bit          LEGACY      = 1'b1,
    // Arbitrary values; the integrator sets the real ones.
    parameter logic [31:0] DEVICE_TYPE = 32'h0000_0001,
    parameter logic [31:0] MAKER_CODE  = 32'h0000_1234
) (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        reg_req,
    input  wire logic                        reg_we,
    input  wire logic [mvd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    output logic [31:0]                      reg_rdata,
    output logic                             reg_rvalid,
    input  wire logic [FEAT_WORDS*32-1:0]    offered_features,
    input  wire logic                        used_ring_event,
    input  wire logic                        config_change_event,
    output logic                             irq,
    output logic                             kick_valid,
    output logic [31:0]                      kick_index,
    output logic                             device_reset,
    output logic [31:0]                      status,
    output logic [31:0]                      driver_page_bytes,
    output logic [FEAT_WORDS*32-1:0]         accepted_features,
    output logic [NUM_QUEUES-1:0]            vq_enabled,
    output logic [NUM_QUEUES*32-1:0]         vq_elements,
    output logic [NUM_QUEUES*32-1:0]         vq_used_ring_alignment,
    output logic [NUM_QUEUES*32-1:0]         vq_page_number,
    output logic [NUM_QUEUES*64-1:0]         vq_descriptor_addr,
    output logic [NUM_QUEUES*64-1:0]         vq_offered_ring_addr,
    output logic [NUM_QUEUES*64-1:0]         vq_completed_ring_addr,
    output logic [CFG_WORDS*32-1:0]          cfg_space
);
    import mvd_pkg::*;

    localparam int unsigned QI_W = $clog2(NUM_QUEUES);
    localparam int unsigned FI_W = $clog2(FEAT_WORDS);
    localparam int unsigned CI_W = $clog2(CFG_WORDS);
    localparam logic [31:0] QMAX = 32'(QUEUE_MAX);

    if (NUM_QUEUES < 2 || FEAT_WORDS < 2 || CFG_WORDS < 2 || CFG_WORDS > 64
        || QUEUE_MAX < 1 || QUEUE_MAX > 32768) begin : g_bad_params
        $error("mvd_top parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode. Data is little-endian: byte 0 of a register is wdata[7:0].

    logic [31:0]   vq_sel_q;
    logic [31:0]   offer_sel_q;
    logic [31:0]   accept_sel_q;
    logic [31:0]   cfg_gen_q;
    logic [IRQ_W-1:0] irq_cause_q;

    wire wr = reg_req && reg_we;
    wire rd = reg_req && !reg_we;
    wire hit_kick   = wr && (reg_addr == OFF_VQ_KICK);
    wire hit_clear  = wr && (reg_addr == OFF_IRQ_CLEAR);
    wire hit_status = wr && (reg_addr == OFF_STATUS);
    wire hit_cfg    = (reg_addr >= OFF_CFG_SPACE)
                   && (reg_addr < OFF_CFG_SPACE + 12'(CFG_WORDS * 4));
    wire [11:0] cfg_off = reg_addr - OFF_CFG_SPACE;
    wire [CI_W-1:0] cfg_idx = cfg_off[CI_W+1:2];
    wire dev_rst_wr = hit_status && (reg_wdata == ZERO_WORD);

    // Selected queue exists only below NUM_QUEUES; others read as absent.
    wire sel_valid = vq_sel_q < 32'(NUM_QUEUES);
    wire [QI_W-1:0] sel_idx = vq_sel_q[QI_W-1:0];
    wire fsel_ok = offer_sel_q < 32'(FEAT_WORDS);
    wire fsel_acc_ok = accept_sel_q < 32'(FEAT_WORDS);

    // Queue field targeted by a write; alignment and enabled share one offset.
    wire [3:0] qfield =
        (reg_addr == OFF_VQ_ELEMS) ? QF_ELEMS :
        (reg_addr == OFF_VQ_ALIGN && LEGACY) ? QF_ALIGN :
        (reg_addr == OFF_VQ_READY && !LEGACY) ? QF_READY :
        (reg_addr == OFF_VQ_PFN && LEGACY) ? QF_PFN :
        (reg_addr == OFF_DESC_LO && !LEGACY) ? QF_DESC_LO :
        (reg_addr == OFF_DESC_HI && !LEGACY) ? QF_DESC_HI :
        (reg_addr == OFF_OFFER_LO && !LEGACY) ? QF_OFFR_LO :
        (reg_addr == OFF_OFFER_HI && !LEGACY) ? QF_OFFR_HI :
        (reg_addr == OFF_DONE_LO && !LEGACY) ? QF_DONE_LO :
        (reg_addr == OFF_DONE_HI && !LEGACY) ? QF_DONE_HI : QF_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Queues.

    logic [31:0] q_elems [NUM_QUEUES];
    logic [31:0] q_align [NUM_QUEUES];
    logic [31:0] q_pfn   [NUM_QUEUES];

    for (genvar i = 0; i < NUM_QUEUES; i++) begin : g_queue
        wire q_wr = wr && sel_valid && (sel_idx == QI_W'(i));
        mvd_queue u_queue (
            .mclk      (mclk),
            .resetn    (resetn),
            .wr_en     (q_wr),
            .wr_field  (qfield),
            .wr_data   (reg_wdata),
            .dev_reset (device_reset),
            .ready_q   (vq_enabled[i]),
            .elems_q   (q_elems[i]),
            .align_q   (q_align[i]),
            .pfn_q     (q_pfn[i]),
            .desc_q    (vq_descriptor_addr[i*64 +: 64]),
            .offr_q    (vq_offered_ring_addr[i*64 +: 64]),
            .done_q    (vq_completed_ring_addr[i*64 +: 64])
        );
        assign vq_elements[i*32 +: 32]            = q_elems[i];
        assign vq_used_ring_alignment[i*32 +: 32] = q_align[i];
        assign vq_page_number[i*32 +: 32]         = q_pfn[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux.

    wire [31:0] max_rd   = sel_valid ? QMAX : ZERO_WORD;
    wire [31:0] pfn_rd   = sel_valid ? q_pfn[sel_idx] : ZERO_WORD;
    wire [31:0] ready_rd = sel_valid ? {31'h0000_0000, vq_enabled[sel_idx]} : ZERO_WORD;
    wire [31:0] feat_rd  = fsel_ok ? offered_features[offer_sel_q[FI_W-1:0]*32 +: 32]
                                   : ZERO_WORD;
    wire [31:0] cfg_rd   = cfg_space[cfg_idx*32 +: 32];
    wire [31:0] ver_rd   = LEGACY ? VERSION_LEGACY : VERSION_CURRENT;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = ZERO_WORD;
        if (hit_cfg) begin
            rd_mux = cfg_rd;
        end else begin
            unique case (reg_addr)
                OFF_IDENT:      rd_mux = IDENT_VALUE;
                OFF_VERSION:    rd_mux = ver_rd;
                OFF_DEV_TYPE:   rd_mux = DEVICE_TYPE;
                OFF_MAKER:      rd_mux = MAKER_CODE;
                OFF_OFFER_FEAT: rd_mux = feat_rd;
                OFF_VQ_MAX:     rd_mux = max_rd;
                OFF_VQ_READY:   rd_mux = LEGACY ? ZERO_WORD : ready_rd;
                OFF_VQ_PFN:     rd_mux = LEGACY ? pfn_rd : ZERO_WORD;
                OFF_IRQ_CAUSE:  rd_mux = {30'h0000_0000, irq_cause_q};
                OFF_STATUS:     rd_mux = status;
                OFF_CFG_GEN:    rd_mux = LEGACY ? ZERO_WORD : cfg_gen_q;
                default:        rd_mux = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= ZERO_WORD;
        end else begin
            reg_rvalid <= rd;
            reg_rdata  <= rd ? rd_mux : ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Plain writable registers.

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vq_sel_q          <= ZERO_WORD;
            offer_sel_q       <= ZERO_WORD;
            accept_sel_q      <= ZERO_WORD;
            driver_page_bytes <= ZERO_WORD;
        end else if (wr) begin
            if (reg_addr == OFF_VQ_SEL) vq_sel_q <= reg_wdata;
            if (reg_addr == OFF_OFFER_SEL) offer_sel_q <= reg_wdata;
            if (reg_addr == OFF_ACCEPT_SEL) accept_sel_q <= reg_wdata;
            if (reg_addr == OFF_PAGE_BYTES && LEGACY) driver_page_bytes <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            accepted_features <= '0;
            cfg_space         <= '0;
        end else if (wr) begin
            if (reg_addr == OFF_ACCEPT_FEAT && fsel_acc_ok)
                accepted_features[accept_sel_q[FI_W-1:0]*32 +: 32] <= reg_wdata;
            if (hit_cfg) cfg_space[cfg_idx*32 +: 32] <= reg_wdata;
        end
    end

    // Status flags accumulate; a zero write resets the device for one cycle.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status       <= ZERO_WORD;
            device_reset <= 1'b0;
        end else begin
            device_reset <= dev_rst_wr;
            if (dev_rst_wr) status <= ZERO_WORD;
            else if (hit_status) status <= status | reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            kick_valid <= 1'b0;
            kick_index <= ZERO_WORD;
        end else begin
            kick_valid <= hit_kick;
            if (hit_kick) kick_index <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt causes. A new event beats a clear or reset in the same cycle.

    wire [IRQ_W-1:0] cause_set = {config_change_event, used_ring_event};
    wire [IRQ_W-1:0] cause_clr = dev_rst_wr ? {IRQ_W{1'b1}} :
                                 hit_clear  ? reg_wdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] cause_d   = (irq_cause_q & ~cause_clr) | cause_set;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_cause_q <= '0;
            irq         <= 1'b0;
            cfg_gen_q   <= ZERO_WORD;
        end else begin
            irq_cause_q <= cause_d;
            irq         <= |cause_d;
            if (config_change_event) cfg_gen_q <= cfg_gen_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
        irq == (|irq_cause_q))
        else $error("interrupt output disagrees with causes");
    AST_IRQ_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        (irq && !hit_clear && !dev_rst_wr) |=> irq)
        else $error("interrupt dropped without a clear");
    AST_USED_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
        used_ring_event |=> irq_cause_q[IRQ_USED_BIT] && irq)
        else $error("used ring event lost");
    AST_CFG_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
        config_change_event |=> irq_cause_q[IRQ_CFG_BIT])
        else $error("configuration change cause lost");
    AST_ACK_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
        (hit_clear && reg_wdata[IRQ_USED_BIT] && !used_ring_event)
        |=> !irq_cause_q[IRQ_USED_BIT])
        else $error("acknowledge did not clear cause");
    AST_KICK: assert property (@(posedge mclk) disable iff (!resetn)
        hit_kick |=> kick_valid && (kick_index == $past(reg_wdata)))
        else $error("kick not forwarded");
    AST_MAX_SIZE: assert property (@(posedge mclk) disable iff (!resetn)
        (rd && reg_addr == OFF_VQ_MAX)
        |=> reg_rvalid
            && (reg_rdata == (($past(vq_sel_q) < 32'(NUM_QUEUES)) ? QMAX : ZERO_WORD)))
        else $error("wrong maximum queue size");
    AST_VERSION: assert property (@(posedge mclk) disable iff (!resetn)
        (rd && reg_addr == OFF_VERSION)
        |=> reg_rdata == (LEGACY ? VERSION_LEGACY : VERSION_CURRENT))
        else $error("version register wrong");
    AST_STATUS_RESET: assert property (@(posedge mclk) disable iff (!resetn)
        dev_rst_wr |=> device_reset && (status == ZERO_WORD)
            && (irq_cause_q == $past(cause_set)))
        else $error("zero status write did not reset");
    AST_STATUS_SET: assert property (@(posedge mclk) disable iff (!resetn)
        (hit_status && !dev_rst_wr)
        |=> ((status & $past(reg_wdata)) == $past(reg_wdata)))
        else $error("status flags not set");

endmodule : mvd_top
`default_nettype wire

// [src/mvd_unused_guard.sv]
// Holds no logic; the transport is built from mvd_top and mvd_queue.

// [testbench/tb_mmio_virtual_device_transport.sv]
// Self-checking testbench for the memory-mapped paravirtual device transport.
`timescale 1ns/1ps
`default_nettype none
module tb_mmio_virtual_device_transport;
    import mvd_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic         mclk;
    logic         resetn;
    logic         reg_req;
    logic         reg_we;
    logic         ev_used;
    logic         ev_cfg;
    logic [11:0]  reg_addr;
    logic [31:0]  reg_wdata;
    logic [31:0]  reg_rdata;
    logic         reg_rvalid;
    logic         irq;
    logic         kick_valid;
    logic [31:0]  kick_index;
    logic         device_reset;
    logic [31:0]  status;
    logic [31:0]  page_bytes;
    logic [63:0]  elems;
    logic [63:0]  align;
    logic [63:0]  pfn;
    logic [127:0] cfg;
    logic [31:0]  rdata_cur;
    logic [1:0]   en_cur;
    logic [127:0] desc_cur;
    int           fails = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    // Device type is arbitrary but nonzero, so a driver would not abort.
    mvd_top #(.DEVICE_TYPE(32'h0000_0005)) uut (
        .mclk(mclk), .resetn(resetn), .reg_req(reg_req), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .offered_features(64'h0000_0002_0000_0001),
        .used_ring_event(ev_used), .config_change_event(ev_cfg), .irq(irq),
        .kick_valid(kick_valid), .kick_index(kick_index), .device_reset(device_reset),
        .status(status), .driver_page_bytes(page_bytes), .accepted_features(),
        .vq_enabled(), .vq_elements(elems), .vq_used_ring_alignment(align),
        .vq_page_number(pfn), .vq_descriptor_addr(), .vq_offered_ring_addr(),
        .vq_completed_ring_addr(), .cfg_space(cfg));

    // A second copy in the current layout shares the bus; only its outputs are separate.
    mvd_top #(.LEGACY(1'b0)) uut_cur (
        .mclk(mclk), .resetn(resetn), .reg_req(reg_req), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata_cur),
        .reg_rvalid(), .offered_features(64'h0000_0002_0000_0001),
        .used_ring_event(ev_used), .config_change_event(ev_cfg), .irq(),
        .kick_valid(), .kick_index(), .device_reset(),
        .status(), .driver_page_bytes(), .accepted_features(),
        .vq_enabled(en_cur), .vq_elements(), .vq_used_ring_alignment(),
        .vq_page_number(), .vq_descriptor_addr(desc_cur), .vq_offered_ring_addr(),
        .vq_completed_ring_addr(), .cfg_space());

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // A hung handshake would otherwise stall the run forever.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Each access leaves one idle cycle so a request is never raised twice in one step.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1 {reg_req, reg_we, reg_addr, reg_wdata} = {2'b11, a, d};
        @(posedge mclk);
        #1 {reg_req, reg_we} = 2'b00;
    endtask

    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk);
        #1 {reg_req, reg_we, reg_addr} = {2'b10, a};
        @(posedge mclk);
        #1 reg_req = 1'b0;
        chk("reg_rvalid", 32'h0000_0001, {31'h0, reg_rvalid});
        chk(name, exp, reg_rdata);
    endtask

    task automatic pulse(input bit cfg_not_used);
        @(posedge mclk);
        #1 {ev_cfg, ev_used} = cfg_not_used ? 2'b10 : 2'b01;
        @(posedge mclk);
        #1 {ev_cfg, ev_used} = 2'b00;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ident();
        rd("identification_value", OFF_IDENT, IDENT_VALUE);
        rd("version", OFF_VERSION, VERSION_LEGACY);
        rd("device_type", OFF_DEV_TYPE, 32'h0000_0005);
        rd("unmapped", 12'h018, ZERO_WORD);
    endtask

    task automatic t_queue();
        wr(OFF_VQ_SEL, 32'h0000_0000);
        rd("vq_max_elements q0", OFF_VQ_MAX, 32'h0000_0100);
        wr(OFF_VQ_SEL, 32'h0000_0002);
        rd("vq_max_elements absent", OFF_VQ_MAX, ZERO_WORD);
        wr(OFF_VQ_SEL, 32'h0000_0001);
        rd("vq_page_number q1 idle", OFF_VQ_PFN, ZERO_WORD);
        wr(OFF_VQ_ELEMS, 32'h0000_0080);
        wr(OFF_VQ_ALIGN, 32'h0000_1000);
        wr(OFF_VQ_PFN, 32'h0000_0123);
        rd("vq_page_number q1", OFF_VQ_PFN, 32'h0000_0123);
        chk("vq_elements q1", 32'h0000_0080, elems[63:32]);
        chk("vq_elements q0", ZERO_WORD, elems[31:0]);
        chk("vq_used_ring_alignment q1", 32'h0000_1000, align[63:32]);
        wr(OFF_VQ_SEL, 32'h0000_0000);
        rd("vq_page_number q0", OFF_VQ_PFN, ZERO_WORD);
    endtask

    task automatic t_status();
        wr(OFF_STATUS, 32'h0000_0003);
        rd("status", OFF_STATUS, 32'h0000_0003);
        wr(OFF_STATUS, 32'h0000_0004);
        rd("status or", OFF_STATUS, 32'h0000_0007);
        pulse(1'b0);
        wr(OFF_STATUS, ZERO_WORD);
        chk("device_reset", 32'h0000_0001, {31'h0, device_reset});
        // Queues see the registered reset pulse, so they stop one edge later.
        @(posedge mclk);
        #1 chk("vq_page_number q1 reset", ZERO_WORD, pfn[63:32]);
        rd("status reset", OFF_STATUS, ZERO_WORD);
        rd("irq_cause reset", OFF_IRQ_CAUSE, ZERO_WORD);
    endtask

    task automatic t_kick();
        wr(OFF_VQ_KICK, 32'h0000_0001);
        chk("kick_valid", 32'h0000_0001, {31'h0, kick_valid});
        chk("kick_index", 32'h0000_0001, kick_index);
        @(posedge mclk);
        #1 chk("kick_valid end", ZERO_WORD, {31'h0, kick_valid});
    endtask

    task automatic t_irq();
        pulse(1'b0);
        rd("irq_cause used", OFF_IRQ_CAUSE, 32'h0000_0001);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        pulse(1'b1);
        rd("irq_cause both", OFF_IRQ_CAUSE, 32'h0000_0003);
        wr(OFF_IRQ_CLEAR, 32'h0000_0001);
        rd("irq_cause cfg", OFF_IRQ_CAUSE, 32'h0000_0002);
        chk("irq held", 32'h0000_0001, {31'h0, irq});
        wr(OFF_IRQ_CLEAR, 32'h0000_0002);
        @(posedge mclk);
        #1 chk("irq off", ZERO_WORD, {31'h0, irq});
    endtask

    task automatic t_misc();
        wr(OFF_PAGE_BYTES, 32'h0000_1000);
        chk("driver_page_bytes", 32'h0000_1000, page_bytes);
        wr(OFF_CFG_SPACE, 32'h0403_0201);
        chk("cfg byte0", 32'h0000_0001, {24'h0, cfg[7:0]});
        chk("cfg byte3", 32'h0000_0004, {24'h0, cfg[31:24]});
    endtask

    task automatic t_current();
        wr(OFF_VQ_SEL, 32'h0000_0001);
        rd("vq_enabled legacy", OFF_VQ_READY, ZERO_WORD);
        chk("vq_enabled q1 idle", ZERO_WORD, rdata_cur);
        wr(OFF_DESC_LO, 32'h0000_2000);
        wr(OFF_DESC_HI, 32'h0000_0001);
        wr(OFF_VQ_READY, 32'h0000_0001);
        chk("vq_descriptor_addr q1 lo", 32'h0000_2000, desc_cur[95:64]);
        chk("vq_descriptor_addr q1 hi", 32'h0000_0001, desc_cur[127:96]);
        chk("vq_enabled", 32'h0000_0002, {30'h0, en_cur});
        rd("config generation legacy", OFF_CFG_GEN, ZERO_WORD);
        chk("config generation", 32'h0000_0001, rdata_cur);
        rd("version legacy again", OFF_VERSION, VERSION_LEGACY);
        chk("version current", VERSION_CURRENT, rdata_cur);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, reg_req, reg_we, ev_used, ev_cfg} = 5'b0;
        reg_addr = 12'h000;
        reg_wdata = ZERO_WORD;
        repeat (8) @(posedge mclk);
        #1 resetn = 1'b1;
        t_ident();
        t_misc();
        t_queue();
        t_kick();
        t_irq();
        t_status();
        t_current();
        close_out();
    end
endmodule // tb_mmio_virtual_device_transport
`default_nettype wire
